/* File: design/rfi_cfg.svh */
/*
 Constants of the two-wire slave port: bus addresses, pointer limits,
 bit counts. Assumes inclusion by bare name from the module.
*/
`ifndef RFI_CFG_SVH
`define RFI_CFG_SVH
`define RFI_RTC_ADDR 7'h68
`define RFI_FRAM_HI 4'hA
`define RFI_FRAM_BIG_ADDR 7'h50
`define RFI_RTC_LAST 8'h12
`define RFI_FRAM_LAST_SMALL 13'h07FF
`define RFI_FRAM_LAST_BIG 13'h1FFF
`define RFI_BIT_LAST 3'h7
`define RFI_BIT_FIRST 3'h0
`define RFI_IDX_DATA 2'h2
`define RFI_IDX_HI 2'h1
`define RFI_IDX_FIRST 2'h0
`endif

/* File: design/rfi_pkg.sv */
/*
 Types of the two-wire slave port.
 Assumes the constants header sits in the same folder.
*/
package rfi_pkg;
    typedef enum logic [5:0] {
        RFI_IDLE = 6'h01,
        RFI_DEV = 6'h02,
        RFI_RX = 6'h04,
        RFI_ACK = 6'h08,
        RFI_TX = 6'h10,
        RFI_MACK = 6'h20
    } rfi_state_t;
endpackage

/* File: design/rfi_slave_port.sv */
/*
 Two-wire slave port of a clock chip with nonvolatile memory: condition
 detection, address decode, pointer loading and byte streaming.
 Assumes scl and sda arrive asynchronously, the system clock is far faster
 than the bus clock, and mem_rdata follows mem_raddr combinationally.
*/
// Function
// R01 - Idle only while both lines high
// R02 - Master starts only on idle bus
// R03 - Data fall with clock high: START
// R04 - Data rise with clock high: STOP
// R05 - Data changes only while clock low
// R06 - Eight bits MSB first, then acknowledge
// R07 - Address and data both MSB first
// R08 - Master gives ninth clock, all conditions
// R09 - Acknowledge holds data low through high
// R10 - Release data after master not-acknowledge
// R11 - No limit on byte count
// R12 - Repeated START restarts address decoding
// R13 - Works at 100kHz and 400kHz
// R14 - Answer timekeeping address 1101000
// R15 - Small memory: 1010 plus block bits
// R16 - Large memory: answer address 1010000
// R17 - Direction bit: zero write, one read
// R18 - Acknowledge every matching address byte
// R19 - Write: pointer byte, then data bytes
// R20 - Large memory takes two pointer bytes
// R21 - Read starts at stored pointer
// R22 - Read continues until not-acknowledge
// R23 - Pointer-only write positions later reads
// R24 - Pointer wraps to zero at end
// R25 - Pointer advances after every data byte
`timescale 1ns/100ps
`include "rfi_cfg.svh"
module rfi_slave_port
    import rfi_pkg::*;
#(
    parameter bit LARGE_MEM = 1'b0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic bus_busy,
    output logic mem_tgt,
    output logic [12:0] mem_raddr,
    input wire logic [7:0] mem_rdata,
    output logic mem_we,
    output logic mem_wtgt,
    output logic [12:0] mem_waddr,
    output logic [7:0] mem_wdata
);
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic scl_rise, scl_fall, start_det, stop_det;
    rfi_state_t st, next_st;
    logic [2:0] bitc, next_bitc;
    logic [7:0] sh, next_sh;
    logic [1:0] bidx, next_bidx;
    logic [7:0] rtc_ptr, next_rtc_ptr;
    logic [12:0] fram_ptr, next_fram_ptr;
    logic full, next_full;
    logic rw, next_rw;
    logic tgt, next_tgt;
    logic mack, next_mack;
    logic oe, next_oe;
    logic busy, next_busy;
    logic next_we, next_wtgt;
    logic [12:0] next_waddr;
    logic [7:0] next_wdata;
    logic rtc_hit, fram_hit;

    // R13 two-stage synchronisers
    // Edges come from the second stage only; a 10 ns clock leaves
    // ample margin against a 1.25 us half period at fast mode.
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
        end else if (ce) begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_p <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    // R03 start while clock high
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    // R04 stop while clock high
    assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

    // R14 timekeeping address
    assign rtc_hit = sh[7:1] == `RFI_RTC_ADDR;
    // R15 R16 memory address by variant
    assign fram_hit = LARGE_MEM ? (sh[7:1] == `RFI_FRAM_BIG_ADDR) : (sh[7:4] == `RFI_FRAM_HI);

    function automatic logic [7:0] rtc_adv(input logic [7:0] p);
        // R24 wrap at end of register space
        rtc_adv = (p == `RFI_RTC_LAST) ? 8'h00 : p + 8'h01;
    endfunction

    function automatic logic [12:0] fram_adv(input logic [12:0] p);
        logic [12:0] last;
        last = LARGE_MEM ? `RFI_FRAM_LAST_BIG : `RFI_FRAM_LAST_SMALL;
        // R24 wrap at end of memory
        fram_adv = (p == last) ? 13'h0000 : p + 13'h0001;
    endfunction

    assign mem_tgt = tgt;
    assign mem_raddr = tgt ? fram_ptr : {5'h00, rtc_ptr};
    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe;
    assign bus_busy = busy;

    always_comb begin
        logic load;
        load = 1'b0;
        next_st = st;
        next_bitc = bitc;
        next_sh = sh;
        next_bidx = bidx;
        next_rtc_ptr = rtc_ptr;
        next_fram_ptr = fram_ptr;
        next_full = full;
        next_rw = rw;
        next_tgt = tgt;
        next_mack = mack;
        next_oe = oe;
        next_busy = busy;
        next_we = 1'b0;
        next_wtgt = mem_wtgt;
        next_waddr = mem_waddr;
        next_wdata = mem_wdata;
        if (stop_det) begin
            // R04 stop ends transfer
            next_st = RFI_IDLE;
            next_oe = 1'b0;
            next_busy = 1'b0;
            next_full = 1'b0;
        end else if (start_det) begin
            // R12 repeated start decodes anew
            next_st = RFI_DEV;
            next_bitc = `RFI_BIT_FIRST;
            next_oe = 1'b0;
            next_busy = 1'b1;
            next_full = 1'b0;
        end else begin
            unique case (st)
                RFI_IDLE: begin
                end
                RFI_DEV, RFI_RX: begin
                    // R06 R07 shift in MSB first
                    if (scl_rise) begin
                        next_sh = {sh[6:0], sda_s};
                        next_bitc = bitc + 3'h1;
                        if (bitc == `RFI_BIT_LAST) begin
                            next_full = 1'b1;
                        end
                    end
                    if (scl_fall && full) begin
                        next_full = 1'b0;
                        next_st = RFI_ACK;
                        next_oe = 1'b1;
                        if (st == RFI_DEV) begin
                            next_bidx = `RFI_IDX_FIRST;
                            // R17 direction bit
                            next_rw = sh[0];
                            if (rtc_hit) begin
                                next_tgt = 1'b0;
                            end else if (fram_hit) begin
                                next_tgt = 1'b1;
                                if (!LARGE_MEM) begin
                                    next_fram_ptr[10:8] = sh[3:1];
                                end
                            end else begin
                                // Not ours: stay off the bus until next start
                                next_st = RFI_IDLE;
                                next_oe = 1'b0;
                            end
                        end else if (bidx == `RFI_IDX_DATA) begin
                            // R19 data byte written at pointer
                            next_we = 1'b1;
                            next_wtgt = tgt;
                            next_wdata = sh;
                            next_waddr = mem_raddr;
                            // R25 advance after each byte
                            if (tgt) begin
                                next_fram_ptr = fram_adv(fram_ptr);
                            end else begin
                                next_rtc_ptr = rtc_adv(rtc_ptr);
                            end
                        end else if (tgt && LARGE_MEM && bidx == `RFI_IDX_FIRST) begin
                            // R20 high pointer byte first
                            next_fram_ptr[12:8] = sh[4:0];
                            next_bidx = `RFI_IDX_HI;
                        end else begin
                            // R23 pointer byte alone positions reads
                            if (tgt) begin
                                next_fram_ptr[7:0] = sh;
                            end else begin
                                next_rtc_ptr = sh;
                            end
                            next_bidx = `RFI_IDX_DATA;
                        end
                    end
                end
                RFI_ACK: begin
                    // R09 hold low until ack clock falls
                    if (scl_fall) begin
                        next_bitc = `RFI_BIT_FIRST;
                        if (rw) begin
                            load = 1'b1;
                        end else begin
                            next_oe = 1'b0;
                            next_st = RFI_RX;
                        end
                    end
                end
                RFI_TX: begin
                    // R05 change data only after clock fall
                    if (scl_fall) begin
                        if (bitc == `RFI_BIT_LAST) begin
                            next_oe = 1'b0;
                            next_st = RFI_MACK;
                        end else begin
                            next_sh = {sh[6:0], 1'b0};
                            next_oe = ~sh[6];
                            next_bitc = bitc + 3'h1;
                        end
                    end
                end
                RFI_MACK: begin
                    if (scl_rise) begin
                        next_mack = ~sda_s;
                    end
                    if (scl_fall) begin
                        next_bitc = `RFI_BIT_FIRST;
                        // R22 R11 continue while acknowledged
                        if (mack) begin
                            load = 1'b1;
                        end else begin
                            // R10 release after not-acknowledge
                            next_st = RFI_IDLE;
                            next_oe = 1'b0;
                        end
                    end
                end
            endcase
        end
        if (load) begin
            // R21 read from stored pointer
            next_sh = mem_rdata;
            next_oe = ~mem_rdata[7];
            next_st = RFI_TX;
            // R25 advance after byte taken
            if (tgt) begin
                next_fram_ptr = fram_adv(fram_ptr);
            end else begin
                next_rtc_ptr = rtc_adv(rtc_ptr);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st <= RFI_IDLE;
            bitc <= `RFI_BIT_FIRST;
            sh <= 8'h00;
            bidx <= `RFI_IDX_FIRST;
            rtc_ptr <= 8'h00;
            fram_ptr <= 13'h0000;
            full <= 1'b0;
            rw <= 1'b0;
            tgt <= 1'b0;
            mack <= 1'b0;
            oe <= 1'b0;
            busy <= 1'b0;
            mem_we <= 1'b0;
            mem_wtgt <= 1'b0;
            mem_waddr <= 13'h0000;
            mem_wdata <= 8'h00;
        end else if (ce) begin
            st <= next_st;
            bitc <= next_bitc;
            sh <= next_sh;
            bidx <= next_bidx;
            rtc_ptr <= next_rtc_ptr;
            fram_ptr <= next_fram_ptr;
            full <= next_full;
            rw <= next_rw;
            tgt <= next_tgt;
            mack <= next_mack;
            oe <= next_oe;
            busy <= next_busy;
            mem_we <= next_we;
            mem_wtgt <= next_wtgt;
            mem_waddr <= next_waddr;
            mem_wdata <= next_wdata;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst || !ce);

    sequence s_addr_done;
        st == RFI_DEV && full && scl_fall && !start_det && !stop_det;
    endsequence

    sequence s_nack_end;
        st == RFI_MACK && !mack && scl_fall && !start_det && !stop_det;
    endsequence

    a_start_enter: assert property (start_det && !stop_det |=> st == RFI_DEV && !sda_oe) // R03
        else $error("start not entered");
    a_stop_idle: assert property (stop_det |=> st == RFI_IDLE && !sda_oe && !bus_busy) // R04
        else $error("stop did not idle");
    a_idle_quiet: assert property (st == RFI_IDLE |-> !sda_oe) // R01
        else $error("driving while idle");
    a_addr_ack: assert property (s_addr_done ##0 (rtc_hit || fram_hit) |=> st == RFI_ACK && sda_oe) // R18
        else $error("address not acknowledged");
    a_addr_miss: assert property (s_addr_done ##0 !(rtc_hit || fram_hit) |=> st == RFI_IDLE) // R14
        else $error("foreign address answered");
    a_ack_hold: assert property (st == RFI_ACK && !scl_fall && !start_det && !stop_det |=> sda_oe) // R09
        else $error("ack released early");
    a_sda_timing: assert property ($changed(sda_oe) && !$past(start_det) && !$past(stop_det) |-> !scl_s) // R05
        else $error("data moved while clock high");
    a_nack_release: assert property (s_nack_end |=> st == RFI_IDLE ##1 !sda_oe) // R10
        else $error("not released after nack");
    a_ptr_step: assert property (mem_we && !mem_wtgt && mem_waddr[7:0] != `RFI_RTC_LAST
        |-> rtc_ptr == mem_waddr[7:0] + 8'h01) // R25
        else $error("pointer did not advance");
    a_ptr_wrap: assert property (mem_we && !mem_wtgt && mem_waddr[7:0] == `RFI_RTC_LAST |-> rtc_ptr == 8'h00) // R24
        else $error("pointer did not wrap");
endmodule

/* File: bench/rfi_bus_master.sv */
/*
 Behavioural two-wire bus master driving the slave port.
 Assumes a pull-up on the data line; tasks are called from the bench.
*/
`timescale 1ns/100ps
module rfi_bus_master (
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // Clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (4) @(negedge clk_sys);
    endtask
    // start only from idle or repeated
    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    // one pulse per bit, data set while low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    // eight bits MSB first, ninth clock for acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // acknowledge, or leave high after the last byte
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
endmodule

/* File: bench/tb.sv */
/*
 Self-checking bench of the slave port, small and large memory variants.
 Assumes the bus master model and a combinational memory read stub.
*/
`timescale 1ns/100ps
module tb;
    typedef struct {
        logic [7:0] dev;
        logic [7:0] ptr;
        logic [7:0] data;
        logic exp_ack;
        logic [21:0] exp_wr;
    } rfi_row_t;
    logic clk_sys, nrst, scl, sda_low, sda_w, sda_out, sda_oe, bus_busy, mem_tgt, mem_we, mem_wtgt, ack;
    logic [12:0] mem_raddr, mem_waddr;
    logic [7:0] mem_rdata, mem_wdata, rd;
    logic [21:0] wq[$];
    logic scl2, sda_low2, sda_w2, sda_out2, sda_oe2, bus_busy2, mem_tgt2, mem_we2, mem_wtgt2;
    logic [12:0] mem_raddr2, mem_waddr2;
    logic [7:0] mem_rdata2, mem_wdata2;
    logic [21:0] wq2[$];
    int n_errors = 0;
    int checks = 0;
    rfi_row_t rows[5] = '{
        '{8'hD0, 8'h05, 8'hA5, 1'b1, {1'b0, 13'h0005, 8'hA5}},
        '{8'hA6, 8'h10, 8'h3C, 1'b1, {1'b1, 13'h0310, 8'h3C}},
        '{8'hAE, 8'hFE, 8'hC3, 1'b1, {1'b1, 13'h07FE, 8'hC3}},
        '{8'hD2, 8'h00, 8'h00, 1'b0, 22'h000000},
        '{8'hB0, 8'h00, 8'h00, 1'b0, 22'h000000}};
    function automatic logic [7:0] fdat(input logic t, input logic [12:0] a);
        return t ? (a[7:0] ^ {a[10:8], 5'h1A}) : (a[7:0] + 8'h30);
    endfunction
    assign mem_rdata = fdat(mem_tgt, mem_raddr);
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    rfi_slave_port #(.LARGE_MEM(1'b0)) dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy), .mem_tgt(mem_tgt),
        .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wtgt(mem_wtgt),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
    rfi_bus_master m (.clk_sys(clk_sys), .sda(sda_w), .scl(scl), .sda_low(sda_low));
    // Large variant on a bus of its own, so that its address never meets the small one
    assign mem_rdata2 = fdat(mem_tgt2, mem_raddr2);
    assign sda_w2 = (sda_oe2 ? sda_out2 : 1'b1) & ~sda_low2;
    rfi_slave_port #(.LARGE_MEM(1'b1)) dut2 (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .scl_in(scl2),
        .sda_in(sda_w2), .sda_out(sda_out2), .sda_oe(sda_oe2), .bus_busy(bus_busy2), .mem_tgt(mem_tgt2),
        .mem_raddr(mem_raddr2), .mem_rdata(mem_rdata2), .mem_we(mem_we2), .mem_wtgt(mem_wtgt2),
        .mem_waddr(mem_waddr2), .mem_wdata(mem_wdata2));
    rfi_bus_master m2 (.clk_sys(clk_sys), .sda(sda_w2), .scl(scl2), .sda_low(sda_low2));
    always @(posedge clk_sys) begin
        if (mem_we2 === 1'b1) begin
            wq2.push_back({mem_wtgt2, mem_waddr2, mem_wdata2});
        end
    end
    always @(posedge clk_sys) begin
        if (mem_we === 1'b1) begin
            wq.push_back({mem_wtgt, mem_waddr, mem_wdata});
        end
    end
    task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_wr(input logic [21:0] exp);
        logic [21:0] got;
        got = 'x;
        if (wq.size() > 0) begin
            got = wq.pop_front();
        end
        chk("write", exp, got);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Guard against a hung run
    initial begin
        #900000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        nrst = 1'b0;
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("oe_rst", 22'h0, sda_oe);
        chk("busy_rst", 22'h0, bus_busy);
        foreach (rows[i]) begin
            m.start();
            m.wr_byte(rows[i].dev, ack);
            chk("addr_ack", rows[i].exp_ack, ack);
            if (ack === 1'b1) begin
                m.wr_byte(rows[i].ptr, ack);
                m.wr_byte(rows[i].data, ack);
                chk("data_ack", 22'h1, ack);
            end
            m.stop();
            if (rows[i].exp_ack) begin
                chk_wr(rows[i].exp_wr);
            end
            chk("wr_count", 22'h0, 22'(wq.size()));
        end
        // Pointer-only write, then a read across the top of the register map
        m.start();
        chk("busy_on", 22'h1, bus_busy);
        m.wr_byte(8'hD0, ack);
        m.wr_byte(8'h11, ack);
        m.stop();
        chk("busy_off", 22'h0, bus_busy);
        chk("no_write", 22'h0, 22'(wq.size()));
        m.start();
        m.wr_byte(8'hD1, ack);
        chk("rd_ack", 22'h1, ack);
        m.rd_byte(1'b1, rd);
        chk("rd0", fdat(1'b0, 13'h0011), rd);
        m.rd_byte(1'b1, rd);
        chk("rd1", fdat(1'b0, 13'h0012), rd);
        m.rd_byte(1'b0, rd);
        chk("rd2", fdat(1'b0, 13'h0000), rd);
        chk("released", 22'h0, sda_oe);
        m.stop();
        // Repeated start turns a pointer write into a read
        m.start();
        m.wr_byte(8'hD0, ack);
        m.wr_byte(8'h02, ack);
        m.start();
        m.wr_byte(8'hD1, ack);
        chk("rs_ack", 22'h1, ack);
        m.rd_byte(1'b0, rd);
        chk("rs_rd", fdat(1'b0, 13'h0002), rd);
        m.stop();
        // Memory write crossing the top of the small array
        m.start();
        m.wr_byte(8'hAE, ack);
        m.wr_byte(8'hFF, ack);
        m.wr_byte(8'h11, ack);
        m.wr_byte(8'h22, ack);
        m.stop();
        chk_wr({1'b1, 13'h07FF, 8'h11});
        chk_wr({1'b1, 13'h0000, 8'h22});
        // Block bits of a read address reposition the memory pointer
        m.start();
        m.wr_byte(8'hA5, ack);
        m.rd_byte(1'b0, rd);
        chk("blk_rd", fdat(1'b1, 13'h0201), rd);
        m.stop();
        // Large variant: single memory address, two pointer bytes, wrap at top
        m2.start();
        m2.wr_byte(8'hA2, ack);
        chk("big_miss", 22'h0, ack);
        m2.stop();
        m2.start();
        m2.wr_byte(8'hA0, ack);
        chk("big_ack", 22'h1, ack);
        m2.wr_byte(8'h1F, ack);
        m2.wr_byte(8'hFF, ack);
        m2.wr_byte(8'h5A, ack);
        m2.wr_byte(8'h6B, ack);
        m2.stop();
        chk("big_n", 22'h2, 22'(wq2.size()));
        chk("big_wr0", {1'b1, 13'h1FFF, 8'h5A}, wq2[0]);
        chk("big_wr1", {1'b1, 13'h0000, 8'h6B}, wq2[1]);
        report_and_stop();
    end
endmodule
